// ### pmac_pkg.sv
// Package of constants and types for power mode and ADC control
package pmac_pkg;
   // ----------------------------------------
   // Power modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      PMAC_SLEEP   = 2'h0,
      PMAC_STANDBY = 2'h1,
      PMAC_IDLE    = 2'h3,
      PMAC_RUN     = 2'h2
   } pmac_mode_e;

   // ----------------------------------------
   // Command addresses (5-bit field of command byte)
   // ----------------------------------------
   localparam logic [4:0] ADDR_SLEEP   = 5'h1a;
   localparam logic [4:0] ADDR_STANDBY = 5'h1b;
   localparam logic [4:0] ADDR_IDLE    = 5'h1c;
   localparam logic [4:0] ADDR_RUN     = 5'h1d;
   localparam logic [4:0] ADDR_ADC     = 5'h01;
   localparam logic [4:0] ADDR_OFFSET  = 5'h02;
   localparam int         CMD_BITS     = 8;
   localparam int         ADDR_LSB     = 2;

   // ----------------------------------------
   // ADC register fields and reset value
   // ----------------------------------------
   localparam int         ADC_START_POS = 0;
   localparam int         ADC_MODE_POS  = 1;
   localparam int         ADC_RATE_POS  = 2;
   localparam int         ADC_GAIN_LSB  = 3;
   localparam int         ADC_POSITIVE_INPUT_BUFFER_ENABLE_POS  = 5;
   localparam int         ADC_NEGATIVE_INPUT_BUFFER_ENABLE_POS  = 6;
   localparam int         ADC_POL_POS   = 7;
   localparam logic [7:0] ADC_RESET     = 8'h00;

   // ----------------------------------------
   // Block enable vector positions
   // ----------------------------------------
   localparam int BLK_LOWSUP = 0;
   localparam int BLK_BIAS   = 1;
   localparam int BLK_PLL    = 2;
   localparam int BLK_CLKOUT = 3;
   localparam int BLK_DACS   = 4;
   localparam int BLK_BGAP   = 5;
   localparam int BLK_COMP   = 6;
   localparam int BLK_MUX    = 7;
   localparam int BLK_INBUF  = 8;
   localparam int BLK_ADC    = 9;
   localparam int BLK_W      = 10;
   localparam logic [9:0] STANDBY_SET = 10'h00f;
   localparam logic [9:0] IDLE_SET    = 10'h0ff;
   localparam logic [9:0] RUN_SET     = 10'h3ff;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_NS        = 10;
   localparam int FIRST_MS      = 100;
   localparam int RATE_HZ       = 30;
   localparam int FIRST_CYC     = FIRST_MS * 1000000 / CLK_NS;
   localparam int PERIOD_CYC    = 1000000000 / (RATE_HZ * CLK_NS);
   localparam int DATA_W        = 16;
   localparam int DAC_W         = 10;
endpackage : pmac_pkg

// ### pmac_dac_map.sv
// Unipolar DAC code to output fraction mapping
`timescale 1ns/1ps
`default_nettype none
module pmac_dac_map (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [9:0]  dacCode,
   input  wire logic        dacOn,
   output logic      [9:0]  dacLevel
);
   // ----------------------------------------
   // Output = reference * code / 1024
   // ----------------------------------------
   // Level in 1/1024ths of reference, zero when powered down
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dacLevel <= 10'h000;
      end else begin
         dacLevel <= dacOn ? dacCode : 10'h000;
      end
   end

   // Full-scale code gives 1023/1024 of reference
   fullScale_a: assert property (@(posedge clk) disable iff (!nrst)
      (dacOn && dacCode == 10'h3ff) |=> dacLevel == 10'h3ff)
      else $error("DAC full scale wrong");
endmodule : pmac_dac_map
`default_nettype wire

// ### pmac_ctrl.sv
// Power mode sequencing, wake-up and ADC conversion/calibration control
`timescale 1ns/1ps
`default_nettype none
module pmac_ctrl #(
   parameter int FIRST_CYCLES  = pmac_pkg::FIRST_CYC,
   parameter int PERIOD_CYCLES = pmac_pkg::PERIOD_CYC
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        cmdValid,
   input  wire logic [7:0]  cmdByte,
   input  wire logic        dataValid,
   input  wire logic [15:0] dataWord,
   input  wire logic        wake_input_one_n,
   input  wire logic        wake_input_two_n,
   input  wire logic        alarmEvent,
   input  wire logic [15:0] rawResult,
   input  wire logic [9:0]  dacCode,
   output logic      [1:0]  powerMode,
   output logic      [9:0]  blockEnable,
   output logic             external_supply_shutdown_output,
   output logic             clock_output,
   output logic      [7:0]  adcConfig,
   output logic      [15:0] offsetValue,
   output logic      [15:0] dataValue,
   output logic             dataReady,
   output logic             calBusy,
   output logic      [9:0]  dacLevel
);
   // ----------------------------------------
   // Wake input synchronisers
   // ----------------------------------------
   logic [1:0] wakeOneSync_q;
   logic [1:0] wakeTwoSync_q;
   logic [1:0] alarmSync_q;

   // Two flops per outside input
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wakeOneSync_q <= 2'h3;
         wakeTwoSync_q <= 2'h3;
         alarmSync_q   <= 2'h0;
      end else begin
         wakeOneSync_q <= {wakeOneSync_q[0], wake_input_one_n};
         wakeTwoSync_q <= {wakeTwoSync_q[0], wake_input_two_n};
         alarmSync_q   <= {alarmSync_q[0], alarmEvent};
      end
   end

   logic wakeEvent;
   assign wakeEvent = !wakeOneSync_q[1] || !wakeTwoSync_q[1] || alarmSync_q[1];

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   function automatic logic isCmd(input logic [7:0] b, input logic [4:0] a);
      isCmd = b[pmac_pkg::ADDR_LSB +: 5] == a;
   endfunction : isCmd

   logic [4:0] lastAddr_q;
   logic       cmdSleep;
   logic       cmdStandby;
   logic       cmdIdle;
   logic       cmdRun;
   assign cmdSleep   = cmdValid && isCmd(cmdByte, pmac_pkg::ADDR_SLEEP);
   assign cmdStandby = cmdValid && isCmd(cmdByte, pmac_pkg::ADDR_STANDBY);
   assign cmdIdle    = cmdValid && isCmd(cmdByte, pmac_pkg::ADDR_IDLE);
   assign cmdRun     = cmdValid && isCmd(cmdByte, pmac_pkg::ADDR_RUN);

   // Remember the addressed register for the data word
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lastAddr_q <= 5'h00;
      end else if (cmdValid) begin
         lastAddr_q <= cmdByte[pmac_pkg::ADDR_LSB +: 5];
      end
   end

   logic adcWrite;
   logic offsetWrite;
   assign adcWrite    = dataValid && lastAddr_q == pmac_pkg::ADDR_ADC;
   assign offsetWrite = dataValid && lastAddr_q == pmac_pkg::ADDR_OFFSET;

   // ----------------------------------------
   // Power mode and block enables
   // ----------------------------------------
   pmac_pkg::pmac_mode_e mode_q;
   logic [9:0]           blk_q;

   // Mode commands act on the command byte itself, no data needed
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mode_q <= pmac_pkg::PMAC_STANDBY;
         blk_q  <= pmac_pkg::STANDBY_SET;
      end else if (cmdSleep) begin
         mode_q <= pmac_pkg::PMAC_SLEEP;
         blk_q  <= 10'h000;
      end else if (cmdStandby) begin
         mode_q <= pmac_pkg::PMAC_STANDBY;
         blk_q  <= pmac_pkg::STANDBY_SET;
      end else if (cmdIdle) begin
         mode_q <= pmac_pkg::PMAC_IDLE;
         blk_q  <= pmac_pkg::IDLE_SET;
      end else if (cmdRun) begin
         mode_q <= pmac_pkg::PMAC_RUN;
         blk_q  <= pmac_pkg::RUN_SET;
      end else if (wakeEvent) begin
         if (mode_q == pmac_pkg::PMAC_SLEEP) begin
            mode_q <= pmac_pkg::PMAC_STANDBY;
         end
         blk_q <= blk_q | pmac_pkg::STANDBY_SET;
      end
   end

   // Registered outputs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         powerMode                       <= 2'h1;
         blockEnable                     <= pmac_pkg::STANDBY_SET;
         external_supply_shutdown_output <= 1'b1;
         clock_output                    <= 1'b0;
      end else begin
         powerMode                       <= mode_q;
         blockEnable                     <= blk_q;
         external_supply_shutdown_output <= blk_q[pmac_pkg::BLK_BIAS];
         clock_output <= blk_q[pmac_pkg::BLK_CLKOUT] ? !clock_output : 1'b0;
      end
   end

   // ----------------------------------------
   // ADC configuration and offset
   // ----------------------------------------
   logic [7:0]  adc_q;
   logic [15:0] offset_q;
   logic        calDone;
   logic [15:0] calOffset;

   // A host write in the completion cycle wins over the mode-bit clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         adc_q <= pmac_pkg::ADC_RESET;
      end else if (adcWrite) begin
         adc_q <= dataWord[7:0];
      end else if (calDone) begin
         adc_q[pmac_pkg::ADC_MODE_POS]  <= 1'b0;
         adc_q[pmac_pkg::ADC_START_POS] <= 1'b0;
      end
   end

   // Offset from calibration or from the host
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         offset_q <= 16'h0000;
      end else if (calDone) begin
         offset_q <= calOffset;
      end else if (offsetWrite) begin
         offset_q <= dataWord;
      end
   end

   // ----------------------------------------
   // Conversion sequencer
   // ----------------------------------------
   typedef enum logic [1:0] {
      PMAC_C_IDLE = 2'h0,
      PMAC_C_CONV = 2'h1,
      PMAC_C_CAL  = 2'h3
   } pmac_conv_e;

   pmac_conv_e  conv_q;
   logic [31:0] cnt_q;
   logic        adcOn;
   logic        startReq;
   logic        tick;
   assign adcOn    = blk_q[pmac_pkg::BLK_ADC];
   assign startReq = adcWrite && dataWord[pmac_pkg::ADC_START_POS];
   assign tick     = cnt_q == 32'h0000_0001;
   assign calDone  = conv_q == PMAC_C_CAL && tick;
   // Raw reading is signed; two's complement offset
   assign calOffset = rawResult;

   // State and interval counter
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         conv_q <= PMAC_C_IDLE;
         cnt_q  <= 32'h0000_0000;
      end else if (!adcOn) begin
         conv_q <= PMAC_C_IDLE;
         cnt_q  <= 32'h0000_0000;
      end else if (startReq) begin
         conv_q <= dataWord[pmac_pkg::ADC_MODE_POS] ? PMAC_C_CAL : PMAC_C_CONV;
         cnt_q  <= 32'(FIRST_CYCLES);
      end else begin
         case (conv_q)
            PMAC_C_CONV: begin
               cnt_q <= tick ? 32'(PERIOD_CYCLES) : cnt_q - 32'h1;
            end
            PMAC_C_CAL: begin
               if (tick) begin
                  conv_q <= PMAC_C_IDLE;
                  cnt_q  <= 32'h0000_0000;
               end else begin
                  cnt_q <= cnt_q - 32'h1;
               end
            end
            default: begin
               conv_q <= PMAC_C_IDLE;
               cnt_q  <= 32'h0000_0000;
            end
         endcase
      end
   end

   // Result delivery with offset removed
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dataValue <= 16'h0000;
         dataReady <= 1'b0;
      end else begin
         dataReady <= conv_q == PMAC_C_CONV && tick && adcOn;
         if (conv_q == PMAC_C_CONV && tick && adcOn) begin
            dataValue <= rawResult - offset_q;
         end
      end
   end

   // Mirrors of configuration state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         adcConfig   <= pmac_pkg::ADC_RESET;
         offsetValue <= 16'h0000;
         calBusy     <= 1'b0;
      end else begin
         adcConfig   <= adc_q;
         offsetValue <= offset_q;
         calBusy     <= conv_q == PMAC_C_CAL;
      end
   end

   // ----------------------------------------
   // DAC mapping
   // ----------------------------------------
   pmac_dac_map i_pmac_dac_map (
      .clk      (clk),
      .nrst     (nrst),
      .dacCode  (dacCode),
      .dacOn    (blk_q[pmac_pkg::BLK_DACS]),
      .dacLevel (dacLevel)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sleepBlocks_a: assert property (@(posedge clk) disable iff (!nrst)
      cmdSleep |=> blk_q == 10'h000 ##1 !external_supply_shutdown_output)
      else $error("Sleep left blocks on");
   runBlocks_a: assert property (@(posedge clk) disable iff (!nrst)
      cmdRun |=> blk_q == pmac_pkg::RUN_SET && mode_q == pmac_pkg::PMAC_RUN)
      else $error("Run set wrong");
   wakeKeep_a: assert property (@(posedge clk) disable iff (!nrst)
      (wakeEvent && !cmdValid) |=> blk_q[9:4] == $past(blk_q[9:4])
         && blk_q[3:0] == 4'hf)
      else $error("Wake altered blocks");
   wakeSleep_a: assert property (@(posedge clk) disable iff (!nrst)
      (wakeEvent && !cmdValid && mode_q == pmac_pkg::PMAC_SLEEP)
         |=> mode_q == pmac_pkg::PMAC_STANDBY)
      else $error("No wake from sleep");
   idleCmd_a: assert property (@(posedge clk) disable iff (!nrst)
      cmdIdle |=> mode_q == pmac_pkg::PMAC_IDLE ##1 powerMode == 2'h3)
      else $error("Idle command late");
   calClear_a: assert property (@(posedge clk) disable iff (!nrst)
      (calDone && !adcWrite) |=> !adc_q[pmac_pkg::ADC_MODE_POS]
         && offset_q == $past(rawResult))
      else $error("Calibration end wrong");
   subtract_a: assert property (@(posedge clk) disable iff (!nrst)
      (conv_q == PMAC_C_CONV && tick && adcOn)
         |=> dataReady && dataValue == $past(rawResult) - $past(offset_q))
      else $error("Offset not subtracted");
   adcOff_a: assert property (@(posedge clk) disable iff (!nrst)
      !adcOn |=> conv_q == PMAC_C_IDLE ##1 !dataReady)
      else $error("Conversions after power down");
   offsetHost_a: assert property (@(posedge clk) disable iff (!nrst)
      (offsetWrite && !calDone) |=> offset_q == $past(dataWord))
      else $error("Host offset not taken");
   calStart_a: assert property (@(posedge clk) disable iff (!nrst)
      (startReq && adcOn && dataWord[pmac_pkg::ADC_MODE_POS]) |=> conv_q == PMAC_C_CAL)
      else $error("Calibration not started");
endmodule : pmac_ctrl
`default_nettype wire

// ### pmac_host_model.sv
// Host processor model issuing mode commands and register writes
`timescale 1ns/1ps
`default_nettype none
module pmac_host_model (
   input  wire logic        clk,
   output logic             cmdValid,
   output logic      [7:0]  cmdByte,
   output logic             dataValid,
   output logic      [15:0] dataWord
);
   // ----------------------------------------
   // Idle bus levels
   // ----------------------------------------
   initial begin
      cmdValid  = 1'b0;
      cmdByte   = 8'h00;
      dataValid = 1'b0;
      dataWord  = 16'h0000;
   end

   // Eight-bit command, no data bits follow; byte scrambled once released
   task automatic send_cmd(input logic [4:0] addr);
      @(posedge clk);
      cmdValid <= 1'b1;
      cmdByte  <= {1'b0, addr, 2'b00};
      @(posedge clk);
      cmdValid <= 1'b0;
      cmdByte  <= ~{1'b0, addr, 2'b00};
   endtask : send_cmd

   // Command byte then its data word on the next edge
   task automatic write_reg(input logic [4:0] addr, input logic [15:0] word);
      send_cmd(addr);
      dataValid <= 1'b1;
      dataWord  <= word;
      @(posedge clk);
      dataValid <= 1'b0;
      dataWord  <= ~word;
   endtask : write_reg
endmodule : pmac_host_model
`default_nettype wire

// ### pmac_ctrl_test.sv
// Self-checking testbench for power mode and ADC control
`timescale 1ns/1ps
`default_nettype none
module pmac_ctrl_test;
   localparam int FIRST_N  = 20;
   localparam int PERIOD_N = 10;
   logic        clk, nrst, cmdValid, dataValid, wakeOneN, wakeTwoN, alarmEvent;
   logic [7:0]  cmdByte, adcConfig;
   logic [15:0] dataWord, rawResult, offsetValue, dataValue;
   logic [9:0]  dacCode, blockEnable, dacLevel;
   logic [1:0]  powerMode;
   logic        shutdownOut, clockOut, dataReady, calBusy;
   int          failCount = 0;
   int          nCompared = 0;

   // ----------------------------------------
   // Clock, host model and design
   // ----------------------------------------
   initial clk = 1'b0;
   always #5 clk = ~clk;
   pmac_host_model i_pmac_host_model (.clk(clk), .cmdValid(cmdValid), .cmdByte(cmdByte),
      .dataValid(dataValid), .dataWord(dataWord));
   pmac_ctrl #(.FIRST_CYCLES(FIRST_N), .PERIOD_CYCLES(PERIOD_N)) i_pmac_ctrl (.clk(clk),
      .nrst(nrst), .cmdValid(cmdValid), .cmdByte(cmdByte), .dataValid(dataValid),
      .dataWord(dataWord), .wake_input_one_n(wakeOneN), .wake_input_two_n(wakeTwoN),
      .alarmEvent(alarmEvent), .rawResult(rawResult), .dacCode(dacCode),
      .powerMode(powerMode), .blockEnable(blockEnable),
      .external_supply_shutdown_output(shutdownOut), .clock_output(clockOut),
      .adcConfig(adcConfig), .offsetValue(offsetValue), .dataValue(dataValue),
      .dataReady(dataReady), .calBusy(calBusy), .dacLevel(dacLevel));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check_val(input string what, input logic [15:0] expv, input logic [15:0] got);
      nCompared++;
      if (got !== expv) begin
         failCount++;
         $display("CHECK FAILED %s expected %h seen %h", what, expv, got);
      end
   endtask : check_val

   task automatic finish_test;
      if (failCount == 0 && nCompared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   task automatic mode(input logic [4:0] addr);
      i_pmac_host_model.send_cmd(addr);
      settle(2);
   endtask : mode

   task automatic wr(input logic [4:0] addr, input logic [15:0] word);
      i_pmac_host_model.write_reg(addr, word);
   endtask : wr

   // Cycles until dataReady; limit+1 when none came
   task automatic wait_ready(input int limit, output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (dataReady !== 1'b1 && n <= limit);
   endtask : wait_ready

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Each mode in turn: mode code, block set, shutdown and clock output
   task automatic test_modes;
      logic [4:0] addrs [4] = '{pmac_pkg::ADDR_SLEEP, pmac_pkg::ADDR_STANDBY,
                                pmac_pkg::ADDR_IDLE, pmac_pkg::ADDR_RUN};
      logic [1:0] codes [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
      logic [9:0] sets  [4] = '{10'h000, pmac_pkg::STANDBY_SET, pmac_pkg::IDLE_SET,
                                pmac_pkg::RUN_SET};
      logic       co;
      for (int i = 0; i < 4; i++) begin
         mode(addrs[i]);
         check_val("mode", {14'h0000, codes[i]}, {14'h0000, powerMode});
         check_val("blocks", {6'h00, sets[i]}, {6'h00, blockEnable});
         check_val("shutdown", {15'h0000, i != 0}, {15'h0000, shutdownOut});
         co = clockOut;
         settle(1);
         check_val("clock toggling", {15'h0000, i != 0}, {15'h0000, clockOut !== co});
      end
   endtask : test_modes

   // Wake sources from sleep, then a wake in idle keeps the idle set
   task automatic test_wake;
      for (int i = 0; i < 3; i++) begin
         mode(pmac_pkg::ADDR_SLEEP);
         @(posedge clk);
         wakeOneN   <= (i != 0);
         wakeTwoN   <= (i != 1);
         alarmEvent <= (i == 2);
         settle(6);
         check_val("wake mode", 16'h0001, {14'h0000, powerMode});
         check_val("wake blocks", 16'h000f, {6'h00, blockEnable});
         check_val("wake shutdown", 16'h0001, {15'h0000, shutdownOut});
         @(posedge clk);
         wakeOneN   <= 1'b1;
         wakeTwoN   <= 1'b1;
         alarmEvent <= 1'b0;
         settle(4);
      end
      mode(pmac_pkg::ADDR_IDLE);
      @(posedge clk);
      alarmEvent <= 1'b1;
      settle(6);
      check_val("wake keeps idle", 16'h00ff, {6'h00, blockEnable});
      @(posedge clk);
      alarmEvent <= 1'b0;
      settle(4);
   endtask : test_wake

   // Start, first result, steady rate, stop when ADC powers down
   task automatic test_convert;
      int n;
      mode(pmac_pkg::ADDR_RUN);
      wr(pmac_pkg::ADDR_OFFSET, 16'h0000);
      rawResult <= 16'h1234;
      wr(pmac_pkg::ADDR_ADC, 16'h0001);
      wait_ready(FIRST_N + 5, n);
      check_val("first latency", 16'h0001, {15'h0000, n >= FIRST_N && n <= FIRST_N + 3});
      check_val("data", 16'h1234, dataValue);
      wait_ready(PERIOD_N + 5, n);
      check_val("period", PERIOD_N[15:0], n[15:0]);
      mode(pmac_pkg::ADDR_IDLE);
      wait_ready(3 * PERIOD_N, n);
      check_val("stopped", 16'(3 * PERIOD_N + 1), n[15:0]);
   endtask : test_convert

   // Calibration, offset subtraction, host-written negative offset
   task automatic test_calib;
      int n;
      mode(pmac_pkg::ADDR_RUN);
      @(posedge clk);
      rawResult <= 16'h0010;
      wr(pmac_pkg::ADDR_ADC, 16'h0003);
      settle(1);
      check_val("cal busy", 16'h0001, {15'h0000, calBusy});
      n = 0;
      while (calBusy === 1'b1 && n < FIRST_N + 10) begin
         settle(1);
         n++;
      end
      check_val("cal done", 16'h0000, {15'h0000, calBusy});
      check_val("offset", 16'h0010, offsetValue);
      check_val("mode bit", 16'h0000, {15'h0000, adcConfig[pmac_pkg::ADC_MODE_POS]});
      wait_ready(3 * PERIOD_N, n);
      check_val("single cal", 16'(3 * PERIOD_N + 1), n[15:0]);
      @(posedge clk);
      rawResult <= 16'h0100;
      wr(pmac_pkg::ADDR_ADC, 16'h0001);
      wait_ready(FIRST_N + 5, n);
      check_val("corrected", 16'h00f0, dataValue);
      wr(pmac_pkg::ADDR_OFFSET, 16'hfff0);
      settle(1);
      check_val("host offset", 16'hfff0, offsetValue);
      wait_ready(PERIOD_N + 5, n);
      wait_ready(PERIOD_N + 5, n);
      check_val("neg offset", 16'h0110, dataValue);
      mode(pmac_pkg::ADDR_IDLE);
   endtask : test_calib

   // Unipolar DAC codes, and no output once the DACs are off
   task automatic test_dac;
      logic [9:0] codes [6] = '{10'h3ff, 10'h201, 10'h200, 10'h1ff, 10'h001, 10'h000};
      foreach (codes[i]) begin
         @(posedge clk);
         dacCode <= codes[i];
         settle(3);
         check_val("dac level", {6'h00, codes[i]}, {6'h00, dacLevel});
      end
      @(posedge clk);
      dacCode <= 10'h3ff;
      mode(pmac_pkg::ADDR_SLEEP);
      settle(2);
      check_val("dac off", 16'h0000, {6'h00, dacLevel});
   endtask : test_dac

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      nrst = 1'b0;
      wakeOneN = 1'b1;
      wakeTwoN = 1'b1;
      alarmEvent = 1'b0;
      rawResult = 16'h0000;
      dacCode = 10'h000;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      settle(1);
      check_val("reset mode", 16'h0001, {14'h0000, powerMode});
      check_val("reset blocks", 16'h000f, {6'h00, blockEnable});
      check_val("reset adc", {8'h00, pmac_pkg::ADC_RESET}, {8'h00, adcConfig});
      test_modes();
      test_wake();
      test_convert();
      test_calib();
      mode(pmac_pkg::ADDR_IDLE);
      test_dac();
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge clk);
      failCount++;
      finish_test();
   end
endmodule : pmac_ctrl_test
`default_nettype wire
